// File: rtl/cssl_pkg.sv
// Package with register map, field positions and delay chip timing for the source selector
package cssl_pkg;
  localparam int                ADDR_W              = 16;
  localparam int                DATA_W              = 8;
  localparam logic [ADDR_W-1:0] SOURCE_SWITCH_ADDRESS = 16'hfff8;
  localparam logic [ADDR_W-1:0] DELAY_A_ADDR        = 16'h0601;
  localparam logic [ADDR_W-1:0] DELAY_B_ADDR        = 16'h0281;
  localparam int                SW_AUTO_BIT         = 0;
  localparam int                SW_CLK_BIT          = 1;
  localparam int                SW_SYNC_BIT         = 2;
  localparam int                SW_CLK_RD_BIT       = 4;
  localparam int                SW_SYNC_RD_BIT      = 5;
  localparam logic [7:0]        SWITCH_RESET        = 8'h01;
  localparam logic [7:0]        DELAY_RESET         = 8'h00;
  localparam int                DELAY_STEP_PS       = 500;
  localparam int                CLK_PERIOD_NS       = 40;
  // Serial programming clock half period, a least time
  localparam int                PROG_HALF_NS        = 100;
  localparam int                PROG_HALF_CYC       =
    (PROG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int                PROG_BITS           = 8;
endpackage : cssl_pkg

// File: rtl/cssl_source_select.sv
// Clock and sync source selection with delay chip serial programmers
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - Auto mode and master role: both selectors pick local sources.
// - Auto mode and slave role: both selectors pick external sources.
// - Switch bit 0 low: clock selector from bit 1, sync from bit 2.
// - Switch read shows clock selector state in bit 4, plus sync state.
// - Switch register decoded at 0xfff8, writable and readable.
// - Write to 0x601 or 0x281 programs the matching delay chip serially.
// - Red fifo-full LED shows the master role flag.
// - Selector high chooses external source, low chooses local.
// - Sync delay setting 0..255, 0.5 ns per step.
module cssl_source_select
  import cssl_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rstn_in,
  // Register port
  input  wire logic [cssl_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [cssl_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [cssl_pkg::DATA_W-1:0] rdata_out,
  // Role strap from pin
  input  wire logic                       master_role_in,
  // Selectors and LED
  output logic                            clock_source_selector_out,
  output logic                            sync_source_selector_out,
  output logic                            led_fifo_full_out,
  // Delay chip A serial port (sync delay)
  output logic                            dly_a_sclk_out,
  output logic                            dly_a_sdata_out,
  output logic                            dly_a_load_out,
  // Delay chip B serial port (clock delay), then busy for both chips
  output logic                            dly_b_sclk_out,
  output logic                            dly_b_sdata_out,
  output logic                            dly_b_load_out,
  output logic                            dly_busy_out
);
  import cssl_pkg::*;

  typedef enum logic [1:0] {CSSL_IDLE, CSSL_LOW, CSSL_HIGH, CSSL_LOAD} cssl_state_t;

  logic [2:0]        role_sync_q;
  logic              master_role_flag_q;
  logic [7:0]        switch_q;
  logic [7:0]        delay_a_q;
  logic [7:0]        delay_b_q;
  logic              pend_a_q;
  logic              pend_b_q;
  cssl_state_t       state_q;
  logic              chip_b_q;
  logic [7:0]        shift_q;
  logic [3:0]        bit_cnt_q;
  logic [7:0]        tick_cnt_q;
  logic              tick;
  logic              sel_clk_d;
  logic              sel_sync_d;
  logic              wr_a;
  logic              wr_b;

  // Elaboration checks on the constants the logic is built around
  if (PROG_HALF_CYC < 1 || PROG_HALF_CYC > 255)
  begin : g_bad_half
    $error("Programming half period does not fit the tick counter");
  end
  if (PROG_BITS != DATA_W || PROG_BITS > 15)
  begin : g_bad_bits
    $error("Programming word must match the delay register width");
  end
  if (SW_CLK_RD_BIT == SW_SYNC_RD_BIT || SW_SYNC_RD_BIT >= DATA_W)
  begin : g_bad_rd_bits
    $error("Selector readback bits must be distinct and inside the word");
  end
  if (SW_AUTO_BIT > 2 || SW_CLK_BIT > 2 || SW_SYNC_BIT > 2)
  begin : g_bad_sw_bits
    $error("Switch control bits must lie in the stored field");
  end
  if (SOURCE_SWITCH_ADDRESS == DELAY_A_ADDR || SOURCE_SWITCH_ADDRESS == DELAY_B_ADDR ||
      DELAY_A_ADDR == DELAY_B_ADDR)
  begin : g_bad_map
    $error("Register addresses must be distinct");
  end

  // Role pin through three flops, change taken when last two agree
  // Flag starts as slave until the pin has settled
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      role_sync_q        <= 3'h0;
      master_role_flag_q <= 1'b0;
    end
    else
    begin
      role_sync_q <= {role_sync_q[1:0], master_role_in};
      if (role_sync_q[1] == role_sync_q[2])
        master_role_flag_q <= role_sync_q[2];
    end
  end

  assign wr_a = wr_in && (addr_in == DELAY_A_ADDR);
  assign wr_b = wr_in && (addr_in == DELAY_B_ADDR);

  // Switch register; only the three control bits are stored
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      switch_q <= SWITCH_RESET;
    else if (wr_in && addr_in == SOURCE_SWITCH_ADDRESS)
      switch_q <= {5'h00, wdata_in[2:0]};
  end

  // Delay settings, kept for readback and for the programmer
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      delay_a_q <= DELAY_RESET;
      delay_b_q <= DELAY_RESET;
    end
    else
    begin
      if (wr_a)
        delay_a_q <= wdata_in;
      if (wr_b)
        delay_b_q <= wdata_in;
    end
  end

  // Selector choice; high means external
  always_comb
  begin
    if (switch_q[SW_AUTO_BIT])
    begin
      sel_clk_d  = !master_role_flag_q;
      sel_sync_d = !master_role_flag_q;
    end
    else
    begin
      sel_clk_d  = switch_q[SW_CLK_BIT];
      sel_sync_d = switch_q[SW_SYNC_BIT];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      clock_source_selector_out <= 1'b0;
      sync_source_selector_out  <= 1'b0;
      led_fifo_full_out         <= 1'b0;
    end
    else
    begin
      clock_source_selector_out <= sel_clk_d;
      sync_source_selector_out  <= sel_sync_d;
      led_fifo_full_out         <= master_role_flag_q;
    end
  end

  // Read data, valid the cycle after the strobe
  // Selector bits show the driven pins, not the stored request
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        SOURCE_SWITCH_ADDRESS:
        begin
          rdata_out                 <= {5'h00, switch_q[2:0]};
          rdata_out[SW_CLK_RD_BIT]  <= clock_source_selector_out;
          rdata_out[SW_SYNC_RD_BIT] <= sync_source_selector_out;
        end
        DELAY_A_ADDR: rdata_out <= delay_a_q;
        DELAY_B_ADDR: rdata_out <= delay_b_q;
        default:      rdata_out <= 8'h00;
      endcase
    end
    else
      rdata_out <= 8'h00;
  end

  // Pending program requests; a new write wins over the clear
  // Chip A goes first when both are waiting
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      pend_a_q <= 1'b0;
      pend_b_q <= 1'b0;
    end
    else
    begin
      if (wr_a)
        pend_a_q <= 1'b1;
      else if (state_q == CSSL_IDLE && pend_a_q)
        pend_a_q <= 1'b0;
      if (wr_b)
        pend_b_q <= 1'b1;
      else if (state_q == CSSL_IDLE && !pend_a_q && pend_b_q)
        pend_b_q <= 1'b0;
    end
  end

  // Half period enable divider
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in || state_q == CSSL_IDLE || tick)
      tick_cnt_q <= 8'h00;
    else
      tick_cnt_q <= tick_cnt_q + 8'h01;
  end
  assign tick = (tick_cnt_q == 8'(PROG_HALF_CYC - 1));

  // Serial shifter, MSB first, load pulse after the last bit
  // Setting is copied at start, so a later write queues a rerun
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state_q   <= CSSL_IDLE;
      chip_b_q  <= 1'b0;
      shift_q   <= 8'h00;
      bit_cnt_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        CSSL_IDLE:
          if (pend_a_q || pend_b_q)
          begin
            chip_b_q  <= !pend_a_q;
            shift_q   <= pend_a_q ? delay_a_q : delay_b_q;
            bit_cnt_q <= 4'h0;
            state_q   <= CSSL_LOW;
          end
        CSSL_LOW:
          if (tick)
            state_q <= CSSL_HIGH;
        CSSL_HIGH:
          if (tick)
          begin
            shift_q   <= {shift_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
            state_q   <= (bit_cnt_q == 4'(PROG_BITS - 1)) ? CSSL_LOAD : CSSL_LOW;
          end
        CSSL_LOAD:
          if (tick)
            state_q <= CSSL_IDLE;
        default:
          state_q <= CSSL_IDLE;
      endcase
    end
  end

  // Chip A port; idle levels low so the chip sees no stray edge
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      dly_a_sclk_out  <= 1'b0;
      dly_a_sdata_out <= 1'b0;
      dly_a_load_out  <= 1'b0;
    end
    else
    begin
      dly_a_sclk_out  <= !chip_b_q && state_q == CSSL_HIGH;
      dly_a_sdata_out <= !chip_b_q && state_q != CSSL_IDLE && shift_q[7];
      dly_a_load_out  <= !chip_b_q && state_q == CSSL_LOAD;
    end
  end

  // Chip B port
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      dly_b_sclk_out  <= 1'b0;
      dly_b_sdata_out <= 1'b0;
      dly_b_load_out  <= 1'b0;
    end
    else
    begin
      dly_b_sclk_out  <= chip_b_q && state_q == CSSL_HIGH;
      dly_b_sdata_out <= chip_b_q && state_q != CSSL_IDLE && shift_q[7];
      dly_b_load_out  <= chip_b_q && state_q == CSSL_LOAD;
    end
  end

  // Busy covers a waiting request as well as the shift itself
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      dly_busy_out <= 1'b0;
    else
      dly_busy_out <= state_q != CSSL_IDLE || pend_a_q || pend_b_q;
  end

endmodule : cssl_source_select

// File: verif/cssl_chk.sv
// Port assertions for the source selector
`timescale 1ns/1ps
module cssl_chk (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [15:0] addr_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        clock_source_selector_out,
  input wire logic        sync_source_selector_out,
  input wire logic        led_fifo_full_out,
  input wire logic        dly_a_sclk_out,
  input wire logic        dly_a_load_out,
  input wire logic        dly_b_sclk_out,
  input wire logic        dly_busy_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  idle_data_zero_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  switch_readback_a: assert property (rd_in && addr_in == 16'hfff8 |=>
    rdata_out[5:4] == {$past(sync_source_selector_out), $past(clock_source_selector_out)})
    else $error("switch readback differs from selectors");
  load_pulse_len_a: assert property ($rose(dly_a_load_out) |->
    dly_a_load_out[*3] ##1 !dly_a_load_out)
    else $error("load pulse not three cycles");
  sclk_high_len_a: assert property ($rose(dly_a_sclk_out) |->
    dly_a_sclk_out[*3] ##1 !dly_a_sclk_out)
    else $error("serial clock high phase not three cycles");
  busy_cover_a: assert property (dly_a_sclk_out || dly_a_load_out || dly_b_sclk_out
    |-> dly_busy_out)
    else $error("busy low while shifting");
  write_starts_a: assert property (wr_in && addr_in == 16'h0601 |-> ##[1:4] dly_busy_out)
    else $error("delay write did not start programming");
  one_chip_a: assert property (!(dly_a_sclk_out && dly_b_sclk_out))
    else $error("both chips clocked at once");
  sel_cause_a: assert property ($changed({sync_source_selector_out,
    clock_source_selector_out}) |-> $past(wr_in, 2) || !$past(rstn_in, 2) ||
    led_fifo_full_out != $past(led_fifo_full_out, 2))
    else $error("selector changed without cause");
endmodule : cssl_chk
bind cssl_source_select cssl_chk cssl_chk_i (.*);

// File: verif/cssl_dly_model.sv
// Delay chip model with serial setting input
`timescale 1ns/1ps
module cssl_dly_model (
  input wire logic       sclk_in,
  input wire logic       sdata_in,
  input wire logic       load_in,
  output logic     [7:0] set_out
);
  logic [7:0] sh_q;
  initial set_out = 8'h00;
  always @(posedge sclk_in) sh_q <= {sh_q[6:0], sdata_in};
  // Setting 0..255, half a nanosecond per step
  always @(posedge load_in) set_out <= sh_q;
endmodule : cssl_dly_model

// File: verif/cssl_source_select_tb.sv
// Self-checking bench for the source selector
`timescale 1ns/1ps
module cssl_source_select_tb;
  import cssl_pkg::*;
  logic        clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, role = 0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0]  wdata_in = 8'h00, rdata_out, set_a, set_b, v;
  logic        cs, ss, led, ak, ad, al, bk, bd, bl, busy;
  logic [31:0] seed = 32'hf473;
  int          error_cnt = 0, n_checks = 0;
  always #20 clk_in = ~clk_in;
  cssl_source_select cssl_source_select_i (.clk_in(clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .master_role_in(role), .clock_source_selector_out(cs),
    .sync_source_selector_out(ss), .led_fifo_full_out(led), .dly_a_sclk_out(ak),
    .dly_a_sdata_out(ad), .dly_a_load_out(al), .dly_b_sclk_out(bk),
    .dly_b_sdata_out(bd), .dly_b_load_out(bl), .dly_busy_out(busy));
  cssl_dly_model dly_a_i (.sclk_in(ak), .sdata_in(ad), .load_in(al), .set_out(set_a));
  cssl_dly_model dly_b_i (.sclk_in(bk), .sdata_in(bd), .load_in(bl), .set_out(set_b));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // Auto mode follows role, high selects external
  function automatic logic [7:0] exp_sw(input logic [7:0] w, input logic m);
    logic [1:0] s;
    s = w[0] ? {~m, ~m} : {w[2], w[1]};
    return {2'b00, s, 1'b0, w[2:0]};
  endfunction : exp_sw
  task complete_run(input int f);
    error_cnt += f;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask : rd
  task sw(input logic [7:0] w, input logic m);
    logic [7:0] e;
    e = exp_sw(w, m);
    @(posedge clk_in);
    role <= m;
    wr(SOURCE_SWITCH_ADDRESS, w);
    repeat (8) @(posedge clk_in);
    rd(SOURCE_SWITCH_ADDRESS, e);
    chk({5'h0, led, ss, cs}, {5'h0, m, e[5:4]});
    $display("switch test done");
  endtask : sw
  task idle;
    int n;
    n = 0;
    repeat (4) @(negedge clk_in);
    while (busy !== 1'b0 && n < 400)
    begin
      @(negedge clk_in);
      n++;
    end
    if (n == 400)
      complete_run(1);
  endtask : idle
  initial
  begin
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rd(SOURCE_SWITCH_ADDRESS, exp_sw(SWITCH_RESET, 1'b0));
    sw(SWITCH_RESET, 1'b1);
    sw(SWITCH_RESET, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      sw({v[7:3], i[2:0]}, i[1]);
    end
    rd(16'h1234, 8'h00);
    v = rnd();
    wr(DELAY_A_ADDR, v);
    wr(DELAY_B_ADDR, 8'hff);
    idle();
    chk(set_a, v);
    chk(set_b, 8'hff);
    rd(DELAY_A_ADDR, v);
    rd(DELAY_B_ADDR, 8'hff);
    wr(DELAY_A_ADDR, 8'h5a);
    wr(DELAY_A_ADDR, 8'h00);
    idle();
    chk(set_a, 8'h00);
    rd(DELAY_A_ADDR, 8'h00);
    $display("delay test done");
    complete_run(0);
  end
endmodule : cssl_source_select_tb
